// ===== logic/rlc_params.svh
// Purpose: constants for the rotate-through-carry execution block
// Assumes: included by bare name from logic/ files
// Notes: byte addresses of the register map, flag bit positions, reset values and response codes
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH
`define RLC_OPC_TOP 6'h0D
`define RLC_ILO_MAX 8'h5F
`define RLC_ACCESS_SPLIT 8'h60
`define RLC_ACCESS_HI_BANK 4'hF
`define RLC_ADDR_CTRL 5'h00
`define RLC_ADDR_INSTR 5'h04
`define RLC_ADDR_WREG 5'h08
`define RLC_ADDR_STATUS 5'h0C
`define RLC_ADDR_BANK 5'h10
`define RLC_ADDR_FSR2 5'h14
`define RLC_ADDR_MADDR 5'h18
`define RLC_ADDR_MDATA 5'h1C
`define RLC_MEM_WORDS 4096
`define RLC_CTRL_GO_BIT 0
`define RLC_CTRL_EXT_BIT 1
`define RLC_FLAG_C 0
`define RLC_FLAG_Z 2
`define RLC_FLAG_N 4
`define RLC_RST_WREG 8'h00
`define RLC_RST_STATUS 8'h00
`define RLC_RST_BANK 4'h0
`define RLC_RESP_OKAY 2'h0
`define RLC_RESP_SLVERR 2'h2
`endif

// ===== logic/rlc_pkg.sv
// Purpose: types for the rotate-through-carry execution block
// Assumes: nothing
// Notes: phase states of one instruction cycle
package rlc_pkg;
  typedef enum logic [2:0] {
    RLC_IDLE = 3'b000,
    RLC_Q1 = 3'b001,
    RLC_Q2 = 3'b010,
    RLC_Q3 = 3'b011,
    RLC_Q4 = 3'b100
  } rlc_phase_t;
endpackage : rlc_pkg

// ===== logic/rlc_mem_if.sv
// Purpose: data-memory port between core and its byte file
// Assumes: one clock, synchronous writes
// Notes: read data is combinational from the file
`timescale 1ns/1ns
interface rlc_mem_if;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport core (output addr, output wdata, output we, input rdata);
  modport file (input addr, input wdata, input we, output rdata);
endinterface : rlc_mem_if

// ===== logic/rlc_mem.sv
// Purpose: data-memory byte file, flip-flop storage
// Assumes: one write port, one combinational read port
// Notes: contents cleared at reset
`timescale 1ns/1ns
`include "rlc_params.svh"
module rlc_mem
(
  input wire logic aclk,
  input wire logic aresetn,
  rlc_mem_if.file mem
);
  logic [7:0] store_r [`RLC_MEM_WORDS];
  logic [7:0] wbyte_nxt;

  // next byte at the addressed slot
  always_comb
  begin
    wbyte_nxt = mem.we ? mem.wdata : store_r[mem.addr];
  end

  // storage registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < `RLC_MEM_WORDS; i++)
      begin
        store_r[i] <= 8'h00;
      end
    end
    else
    begin
      store_r[mem.addr] <= wbyte_nxt;
    end
  end

  assign mem.rdata = store_r[mem.addr];
endmodule : rlc_mem

// ===== logic/rlc_core.sv
// Purpose: executes the rotate-left-through-carry byte instruction
// Assumes: AXI4-Lite slave for control, one instruction at a time
// Notes: a legal instruction runs through four phases Q1..Q4, an illegal opcode returns to idle after Q1
`timescale 1ns/1ns
`include "rlc_params.svh"
module rlc_core
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy
);
  rlc_mem_if mem ();
  rlc_mem i_rlc_mem (.aclk(aclk), .aresetn(aresetn), .mem(mem));

  rlc_pkg::rlc_phase_t phase_r, phase_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [7:0] wreg_r, wreg_nxt, status_r, status_nxt, opnd_r, opnd_nxt, res_r, res_nxt;
  logic [3:0] bank_select_register_r, bank_select_register_nxt;
  logic [11:0] fsr2_r, fsr2_nxt, maddr_r, maddr_nxt, ea_r, ea_nxt;
  logic ext_r, ext_nxt, illegal_r, illegal_nxt, cout_r, cout_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [4:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] wbyte;
  logic do_write, go, mdata_wr;

  // operand address formation from the instruction fields
  function automatic logic [11:0] rlc_ea(input logic a_bit, input logic [7:0] f,
                                         input logic [3:0] bank, input logic ext,
                                         input logic [11:0] fsr2);
    logic [11:0] r;
    if (!a_bit && ext && f <= `RLC_ILO_MAX)
      r = 12'(fsr2 + {4'h0, f});
    else if (!a_bit)
      r = (f < `RLC_ACCESS_SPLIT) ? {4'h0, f} : {`RLC_ACCESS_HI_BANK, f};
    else
      r = {bank, f};
    return r;
  endfunction : rlc_ea

  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign wbyte = wdata_r[7:0];
  assign go = do_write && awaddr_r == `RLC_ADDR_CTRL && wdata_r[`RLC_CTRL_GO_BIT]
              && phase_r == rlc_pkg::RLC_IDLE;
  assign mdata_wr = do_write && awaddr_r == `RLC_ADDR_MDATA && phase_r == rlc_pkg::RLC_IDLE;

  // memory port: Q4 writeback or software access
  assign mem.addr = (phase_r == rlc_pkg::RLC_IDLE) ? maddr_r : ea_r;
  assign mem.wdata = (phase_r == rlc_pkg::RLC_Q4) ? res_r : wbyte;
  // write back when destination is file
  assign mem.we = (phase_r == rlc_pkg::RLC_Q4 && instr_r[9]) || mdata_wr;

  // bus handshakes, register writes and the phase sequence
  always_comb
  begin
    phase_nxt = phase_r;
    instr_nxt = instr_r;
    wreg_nxt = wreg_r;
    status_nxt = status_r;
    bank_select_register_nxt = bank_select_register_r;
    fsr2_nxt = fsr2_r;
    maddr_nxt = maddr_r;
    ext_nxt = ext_r;
    illegal_nxt = illegal_r;
    ea_nxt = ea_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    cout_nxt = cout_r;
    aw_hold_nxt = aw_hold_r || s_axi_awvalid;
    w_hold_nxt = w_hold_r || s_axi_wvalid;
    awaddr_nxt = aw_hold_r ? awaddr_r : s_axi_awaddr;
    wdata_nxt = w_hold_r ? wdata_r : s_axi_wdata;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (do_write)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RLC_RESP_OKAY;
      if (awaddr_r == `RLC_ADDR_CTRL)
        ext_nxt = wdata_r[`RLC_CTRL_EXT_BIT];
      else if (awaddr_r[1:0] != 2'b00)
        bresp_nxt = `RLC_RESP_SLVERR;
      // busy: acknowledged but dropped
      else if (phase_r != rlc_pkg::RLC_IDLE)
        bresp_nxt = `RLC_RESP_OKAY;
      else if (awaddr_r == `RLC_ADDR_INSTR)
        instr_nxt = wdata_r[15:0];
      else if (awaddr_r == `RLC_ADDR_WREG)
        wreg_nxt = wbyte;
      else if (awaddr_r == `RLC_ADDR_STATUS)
        status_nxt = wbyte;
      else if (awaddr_r == `RLC_ADDR_BANK)
        bank_select_register_nxt = wdata_r[3:0];
      else if (awaddr_r == `RLC_ADDR_FSR2)
        fsr2_nxt = wdata_r[11:0];
      else if (awaddr_r == `RLC_ADDR_MADDR)
        maddr_nxt = wdata_r[11:0];
    end
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RLC_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr == `RLC_ADDR_CTRL)
        rdata_nxt = {29'h0, illegal_r, ext_r, busy};
      else if (s_axi_araddr == `RLC_ADDR_INSTR)
        rdata_nxt = {16'h0, instr_r};
      else if (s_axi_araddr == `RLC_ADDR_WREG)
        rdata_nxt = {24'h0, wreg_r};
      else if (s_axi_araddr == `RLC_ADDR_STATUS)
        rdata_nxt = {24'h0, status_r};
      else if (s_axi_araddr == `RLC_ADDR_BANK)
        rdata_nxt = {28'h0, bank_select_register_r};
      else if (s_axi_araddr == `RLC_ADDR_FSR2)
        rdata_nxt = {20'h0, fsr2_r};
      else if (s_axi_araddr == `RLC_ADDR_MADDR)
        rdata_nxt = {20'h0, maddr_r};
      else if (s_axi_araddr == `RLC_ADDR_MDATA)
        rdata_nxt = {24'h0, mem.rdata};
      else
        rresp_nxt = `RLC_RESP_SLVERR;
    end
    case (phase_r)
      rlc_pkg::RLC_IDLE:
      begin
        if (go)
          phase_nxt = rlc_pkg::RLC_Q1;
      end
      rlc_pkg::RLC_Q1:
      begin
        illegal_nxt = instr_r[15:10] != `RLC_OPC_TOP;
        ea_nxt = rlc_ea(instr_r[8], instr_r[7:0], bank_select_register_r, ext_r, fsr2_r);
        phase_nxt = (instr_r[15:10] == `RLC_OPC_TOP) ? rlc_pkg::RLC_Q2 : rlc_pkg::RLC_IDLE;
      end
      rlc_pkg::RLC_Q2:
      begin
        opnd_nxt = mem.rdata;
        phase_nxt = rlc_pkg::RLC_Q3;
      end
      rlc_pkg::RLC_Q3:
      begin
        res_nxt = {opnd_r[6:0], status_r[`RLC_FLAG_C]};
        cout_nxt = opnd_r[7];
        phase_nxt = rlc_pkg::RLC_Q4;
      end
      rlc_pkg::RLC_Q4:
      begin
        if (!instr_r[9])
          wreg_nxt = res_r;
        status_nxt[`RLC_FLAG_C] = cout_r;
        status_nxt[`RLC_FLAG_N] = res_r[7];
        status_nxt[`RLC_FLAG_Z] = res_r == 8'h00;
        phase_nxt = rlc_pkg::RLC_IDLE;
      end
      default:
        phase_nxt = rlc_pkg::RLC_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_r <= rlc_pkg::RLC_IDLE;
      instr_r <= 16'h0000;
      wreg_r <= `RLC_RST_WREG;
      status_r <= `RLC_RST_STATUS;
      bank_select_register_r <= `RLC_RST_BANK;
      fsr2_r <= 12'h000;
      maddr_r <= 12'h000;
      ext_r <= 1'b0;
      illegal_r <= 1'b0;
      ea_r <= 12'h000;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      cout_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end
    else
    begin
      phase_r <= phase_nxt;
      instr_r <= instr_nxt;
      wreg_r <= wreg_nxt;
      status_r <= status_nxt;
      bank_select_register_r <= bank_select_register_nxt;
      fsr2_r <= fsr2_nxt;
      maddr_r <= maddr_nxt;
      ext_r <= ext_nxt;
      illegal_r <= illegal_nxt;
      ea_r <= ea_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      cout_r <= cout_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // bus outputs
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign busy = phase_r != rlc_pkg::RLC_IDLE;

  // checks
  rotate_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q3 |=> res_r == {$past(opnd_r[6:0]), $past(status_r[0])}
      && cout_r == $past(opnd_r[7]))
    else $error("rotate result wrong");
  wreg_dest_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q4 && !instr_r[9] |=> wreg_r == $past(res_r))
    else $error("working register not written");
  file_dest_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q4 |-> mem.we == instr_r[9])
    else $error("file writeback wrong");
  access_bank_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q1 && !instr_r[8] && (!ext_r || instr_r[7:0] > 8'h5F)
      |=> ea_r[7:0] == $past(instr_r[7:0])
      && ea_r[11:8] == (($past(instr_r[7:0]) < 8'h60) ? 4'h0 : 4'hF))
    else $error("access bank address wrong");
  bank_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q1 && instr_r[8] |=> ea_r == {$past(bank_select_register_r),
      $past(instr_r[7:0])})
    else $error("banked address wrong");
  indexed_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q1 && !instr_r[8] && ext_r && instr_r[7:0] <= 8'h5F
      |=> ea_r == 12'($past(fsr2_r) + {4'h0, $past(instr_r[7:0])}))
    else $error("indexed address wrong");
  one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q1 && instr_r[15:10] == 6'h0D |=> phase_r == rlc_pkg::RLC_Q2
      ##1 phase_r == rlc_pkg::RLC_Q3 ##1 phase_r == rlc_pkg::RLC_Q4 ##1 !busy)
    else $error("instruction phases wrong");
  flags_upd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == rlc_pkg::RLC_Q4 |=> status_r[4] == $past(res_r[7])
      && status_r[2] == ($past(res_r) == 8'h00) && status_r[0] == $past(cout_r))
    else $error("flags not updated");
endmodule : rlc_core

// ===== sim/rotate_left_through_carry_exec_tb.sv
// Purpose: self-checking bench for the rotate-through-carry block
// Assumes: AXI4-Lite master tasks, byte addresses from rlc_params.svh
// Notes: expected results worked out here from the rotate rules
`timescale 1ns/1ns
`include "rlc_params.svh"
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module rotate_left_through_carry_exec_tb;
  logic aclk;
  logic aresetn;
  logic [4:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [4:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic busy;
  logic [31:0] rd;
  logic [1:0] bresp_last;
  logic [1:0] rresp_last;
  int error_cnt;
  int compares;
  int busy_run;
  int busy_len;

  rlc_core i_rlc_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .busy(busy));

  // free-running core clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // length of the last busy pulse
  always @(posedge aclk)
  begin
    if (busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  // counts and verdict, ends the run
  task report_and_stop;
    $display("Errors: %0d, comparisons: %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // bounded wait ran out
  task wait_out;
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    report_and_stop();
  endtask : wait_out

  // one write, address and data offered together
  task axi_wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        bresp_last = s_axi_bresp;
        done = 1'b1;
      end
      if (n > 200)
        wait_out();
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // one read, data taken at the rvalid edge
  task axi_rd(input logic [4:0] a, output logic [31:0] d);
    int n;
    logic done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        rresp_last = s_axi_rresp;
        done = 1'b1;
      end
      if (n > 200)
        wait_out();
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // preload, run one instruction, check working reg, flags and memory
  task exec(input logic [15:0] ins, input logic ext, input logic [3:0] bank,
    input logic [11:0] fsr2, input logic [11:0] ea, input logic [7:0] val, input logic c);
    logic [7:0] res;
    logic [7:0] st;
    logic legal;
    int n;
    legal = (ins[15:10] === 6'h0D);
    res = {val[6:0], c};
    st = {3'h0, res[7], 1'h0, res == 8'h00, 1'h0, val[7]};
    if (!legal)
      st = {7'h00, c};
    axi_wr(`RLC_ADDR_INSTR, {16'h0000, ins});
    axi_wr(`RLC_ADDR_BANK, {28'h0000000, bank});
    axi_wr(`RLC_ADDR_FSR2, {20'h00000, fsr2});
    axi_wr(`RLC_ADDR_MADDR, {20'h00000, ea});
    axi_wr(`RLC_ADDR_MDATA, {24'h000000, val});
    axi_wr(`RLC_ADDR_WREG, 32'h0000005A);
    axi_wr(`RLC_ADDR_STATUS, {31'h00000000, c});
    axi_wr(`RLC_ADDR_CTRL, {30'h00000000, ext, 1'b1});
    `CHK(bresp_last, `RLC_RESP_OKAY);
    rd = 32'h00000001;
    n = 0;
    while (rd[0] !== 1'b0)
    begin
      axi_rd(`RLC_ADDR_CTRL, rd);
      n++;
      if (n > 50)
        wait_out();
    end
    `CHK(busy_len, legal ? 4 : 1);
    `CHK(rd[2], !legal);
    `CHK(rd[1], ext);
    axi_rd(`RLC_ADDR_WREG, rd);
    `CHK(rd, (legal && !ins[9]) ? {24'h000000, res} : 32'h0000005A);
    axi_rd(`RLC_ADDR_STATUS, rd);
    `CHK(rd, {24'h000000, st});
    axi_rd(`RLC_ADDR_MDATA, rd);
    `CHK(rd, {24'h000000, (legal && ins[9]) ? res : val});
  endtask : exec

  // reset, register reset values, then the instruction cases
  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = 5'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 5'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`RLC_ADDR_WREG, rd);
    `CHK(rd, {24'h000000, `RLC_RST_WREG});
    axi_rd(`RLC_ADDR_STATUS, rd);
    `CHK(rd, {24'h000000, `RLC_RST_STATUS});
    axi_rd(`RLC_ADDR_BANK, rd);
    `CHK(rd, {28'h0000000, `RLC_RST_BANK});
    // unaligned place answers an error with zero data
    axi_rd(5'h02, rd);
    `CHK(rd, 32'h00000000);
    `CHK(rresp_last, `RLC_RESP_SLVERR);
    exec({6'h0D, 2'b00, 8'h20}, 1'b0, 4'h3, 12'h200, 12'h020, 8'hE6, 1'b0);
    exec({6'h0D, 2'b11, 8'h45}, 1'b0, 4'h3, 12'h200, 12'h345, 8'h80, 1'b0);
    exec({6'h0D, 2'b10, 8'h70}, 1'b0, 4'h3, 12'h200, 12'hF70, 8'h01, 1'b1);
    exec({6'h0D, 2'b10, 8'h5F}, 1'b1, 4'h3, 12'h200, 12'h25F, 8'h7F, 1'b1);
    exec({6'h0D, 2'b10, 8'h60}, 1'b1, 4'h3, 12'h200, 12'hF60, 8'h55, 1'b0);
    exec({6'h0D, 2'b11, 8'h5F}, 1'b1, 4'h5, 12'h200, 12'h55F, 8'hC3, 1'b1);
    exec({6'h0D, 2'b00, 8'h20}, 1'b1, 4'h3, 12'hFF0, 12'h010, 8'h9A, 1'b1);
    exec(16'h4520, 1'b0, 4'h3, 12'h200, 12'h020, 8'h12, 1'b1);
    report_and_stop();
  end
endmodule : rotate_left_through_carry_exec_tb
